//--- stcc_top.sv
// slot period counter, clock source select, soft reset and serial port
`timescale 1ns/1ps
`default_nettype none
module stcc_top #(
  parameter int hf_div = 32
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic osc_kilo_clk,
  input wire logic osc_fast_clk,
  input wire logic [3:0] gpio_in,
  output logic miso,
  output logic miso_oe,
  output logic kilo_osc_on,
  output logic fast_slow_osc_on,
  output logic slow_osc_choice,
  output logic [1:0] clock_source_select,
  output logic [1:0] clock_pin_select,
  output logic hf_ext_sel,
  output logic [3:0] clock_pin_route,
  output logic run_state,
  output logic [3:0] slot_count_select,
  output logic [11:0] slot_enable,
  output logic period_tick,
  output logic afe_reset
);

  // slots A.. up to code+1, capped at twelve
  function automatic logic [11:0] slot_mask(input logic [3:0] code);
    logic [11:0] m;
    m = 12'h000;
    for (int i = 0; i < stcc_pkg::slot_max; i++)
      if (i <= int'(code))
        m[i] = 1'b1;
    return m;
  endfunction

  // pin inputs: two flops each, third stage for edges
  logic [8:0] sync1;
  logic [8:0] sync2;
  logic [8:0] prev;
  wire logic [8:0] pins = {gpio_in, osc_fast_clk, osc_kilo_clk, mosi, cs_n,
    sclk};

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1 <= stcc_pkg::sync_rst;
      sync2 <= stcc_pkg::sync_rst;
      prev <= stcc_pkg::sync_rst;
    end
    else
    begin
      sync1 <= pins;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  wire logic [8:0] rise = sync2 & ~prev;
  wire logic sclk_rise = rise[stcc_pkg::ln_sclk];
  wire logic sclk_fall = prev[stcc_pkg::ln_sclk] & ~sync2[stcc_pkg::ln_sclk];
  wire logic cs_high = sync2[stcc_pkg::ln_csn];
  wire logic mosi_s = sync2[stcc_pkg::ln_mosi];

  // register storage
  logic [15:0] period_low;
  logic [6:0] period_high;
  logic [9:0] sys_keep;

  // serial port: 15 address bits, write flag, 16 data bits, msb first
  stcc_pkg::stcc_state_t state;
  stcc_pkg::stcc_state_t next_state;
  logic [3:0] bit_cnt;
  logic [15:0] shin;
  logic [14:0] addr;
  logic wr_flag;
  logic [15:0] shout;

  wire logic half_last = bit_cnt == stcc_pkg::half_frame_last;
  wire logic [15:0] shin_next = {shin[14:0], mosi_s};
  wire logic cmd_end = state == stcc_pkg::st_cmd && sclk_rise && half_last;
  wire logic data_end = state == stcc_pkg::st_data && sclk_rise && half_last;
  wire logic write_now = data_end && wr_flag && !cs_high;
  wire logic [14:0] rd_addr = shin_next[15:1];

  wire logic [15:0] rd_word =
    (rd_addr == stcc_pkg::addr_period_low) ? period_low :
    (rd_addr == stcc_pkg::addr_period_high) ? {9'h000, period_high} :
    (rd_addr == stcc_pkg::addr_system_control) ? {6'h00, sys_keep} :
    (rd_addr == stcc_pkg::addr_operating_mode) ?
      {4'h0, slot_count_select, 7'h00, run_state} : 16'h0000;

  always_comb
  begin
    next_state = state;
    case (state)
      stcc_pkg::st_idle:
        if (!cs_high)
          next_state = stcc_pkg::st_cmd;
      stcc_pkg::st_cmd:
        if (cs_high)
          next_state = stcc_pkg::st_idle;
        else if (cmd_end)
          next_state = stcc_pkg::st_data;
      stcc_pkg::st_data:
        if (cs_high)
          next_state = stcc_pkg::st_idle;
        else if (data_end)
          next_state = stcc_pkg::st_done;
      stcc_pkg::st_done:
        if (cs_high)
          next_state = stcc_pkg::st_idle;
      default:
        next_state = stcc_pkg::st_idle;
    endcase
  end

  // port logic sees arst_n only, never the soft reset
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state <= stcc_pkg::st_idle;
    else
      state <= next_state;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bit_cnt <= 4'h0;
      shin <= 16'h0000;
      addr <= 15'h0000;
      wr_flag <= 1'b0;
    end
    else if (state == stcc_pkg::st_idle)
      bit_cnt <= 4'h0;
    else if (sclk_rise)
    begin
      shin <= shin_next;
      bit_cnt <= bit_cnt + 4'h1;
      if (cmd_end)
      begin
        addr <= rd_addr;
        wr_flag <= mosi_s;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shout <= 16'h0000;
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end
    else
    begin
      if (cmd_end)
        shout <= rd_word;
      else if (state == stcc_pkg::st_data && sclk_fall)
        shout <= {shout[14:0], 1'b0};
      miso <= shout[15];
      miso_oe <= state == stcc_pkg::st_data && !cs_high;
    end
  end

  // register writes and soft reset
  wire logic hit_low = addr == stcc_pkg::addr_period_low;
  wire logic hit_high = addr == stcc_pkg::addr_period_high;
  wire logic hit_sys = addr == stcc_pkg::addr_system_control;
  wire logic hit_mode = addr == stcc_pkg::addr_operating_mode;
  wire logic soft_rst = write_now && hit_sys &&
    shin_next[stcc_pkg::pos_soft_reset];

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      period_low <= stcc_pkg::rst_period_low;
      period_high <= stcc_pkg::rst_period_high;
      sys_keep <= stcc_pkg::rst_system_control;
      slot_count_select <= stcc_pkg::rst_slot_count;
      run_state <= stcc_pkg::rst_run_state;
    end
    else if (soft_rst)
    begin
      // defaults restored; the reset bit itself is never stored
      period_low <= stcc_pkg::rst_period_low;
      period_high <= stcc_pkg::rst_period_high;
      sys_keep <= stcc_pkg::rst_system_control;
      slot_count_select <= stcc_pkg::rst_slot_count;
      run_state <= stcc_pkg::rst_run_state;
    end
    else if (write_now)
    begin
      if (hit_low)
        period_low <= shin_next;
      if (hit_high)
        period_high <= shin_next[6:0];
      if (hit_sys)
        sys_keep <= shin_next[9:0];
      if (hit_mode)
      begin
        slot_count_select <= shin_next[stcc_pkg::pos_slot_lsb +: 4];
        run_state <= shin_next[stcc_pkg::pos_run];
      end
    end
  end

  // control fields
  wire logic [1:0] src_w = sys_keep[stcc_pkg::pos_src_lsb +: 2];
  wire logic [1:0] pin_w = sys_keep[stcc_pkg::pos_pin_lsb +: 2];

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      kilo_osc_on <= 1'b0;
      fast_slow_osc_on <= 1'b0;
      slow_osc_choice <= 1'b0;
      clock_source_select <= 2'b00;
      clock_pin_select <= 2'b00;
      hf_ext_sel <= 1'b0;
      clock_pin_route <= 4'h0;
      slot_enable <= 12'h000;
      afe_reset <= 1'b0;
    end
    else
    begin
      kilo_osc_on <= sys_keep[stcc_pkg::pos_kilo_on];
      fast_slow_osc_on <= sys_keep[stcc_pkg::pos_fast_on];
      slow_osc_choice <= sys_keep[stcc_pkg::pos_choice];
      clock_source_select <= src_w;
      clock_pin_select <= pin_w;
      hf_ext_sel <= src_w[1];
      clock_pin_route <= (src_w == stcc_pkg::src_internal) ? 4'h0 :
        (4'h1 << pin_w);
      slot_enable <= run_state ? slot_mask(slot_count_select) :
        12'h000;
      afe_reset <= soft_rst;
    end
  end

  // low frequency tick from the selected source
  wire logic alt_rise = rise[stcc_pkg::ln_gpio + 32'(pin_w)];
  wire logic int_rise = sys_keep[stcc_pkg::pos_choice] ?
    rise[stcc_pkg::ln_fast] : rise[stcc_pkg::ln_kilo];
  logic [15:0] hf_cnt;
  wire logic hf_last = hf_cnt == 16'(hf_div - 1);
  logic lf_tick;

  always_comb
  begin
    case (stcc_pkg::stcc_src_t'(src_w))
      stcc_pkg::src_internal:
        lf_tick = int_rise;
      stcc_pkg::src_ext_low:
        lf_tick = alt_rise;
      stcc_pkg::src_ext_high:
        lf_tick = int_rise;
      stcc_pkg::src_ext_high_div:
        lf_tick = alt_rise && hf_last;
      default:
        lf_tick = 1'b0;
    endcase
  end

  // period counter
  logic [22:0] count;
  wire logic [22:0] period = {period_high, period_low};
  wire logic [22:0] count_next = count + 23'h000001;
  wire logic period_hit = period != 23'h000000 && count_next >= period;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hf_cnt <= 16'h0000;
      count <= 23'h000000;
      period_tick <= 1'b0;
    end
    else if (soft_rst)
    begin
      hf_cnt <= 16'h0000;
      count <= 23'h000000;
      period_tick <= 1'b0;
    end
    else
    begin
      if (src_w == stcc_pkg::src_ext_high_div && alt_rise)
        hf_cnt <= hf_last ? 16'h0000 : hf_cnt + 16'h0001;
      period_tick <= 1'b0;
      if (!run_state)
        count <= 23'h000000;
      else if (lf_tick)
      begin
        if (period_hit)
        begin
          count <= 23'h000000;
          period_tick <= 1'b1;
        end
        else
          count <= count_next;
      end
    end
  end

endmodule
`default_nettype wire

//--- stcc_pkg.sv
// constants for the slot timing and clock configuration block
package stcc_pkg;
  localparam int addr_w = 15;
  localparam int reg_w = 16;
  localparam int period_w = 23;
  localparam int period_high_w = 7;
  localparam int slot_max = 12;
  localparam int sync_w = 9;
  localparam logic [3:0] half_frame_last = 4'hf;
  localparam logic [14:0] addr_period_low = 15'h000d;
  localparam logic [14:0] addr_period_high = 15'h000e;
  localparam logic [14:0] addr_system_control = 15'h000f;
  localparam logic [14:0] addr_operating_mode = 15'h0010;
  localparam logic [15:0] rst_period_low = 16'h2710;
  localparam logic [6:0] rst_period_high = 7'h00;
  localparam logic [9:0] rst_system_control = 10'h000;
  localparam logic [3:0] rst_slot_count = 4'h0;
  localparam logic rst_run_state = 1'b0;
  localparam int pos_soft_reset = 15;
  localparam int pos_src_lsb = 8;
  localparam int pos_pin_lsb = 6;
  localparam int pos_choice = 2;
  localparam int pos_fast_on = 1;
  localparam int pos_kilo_on = 0;
  localparam int pos_slot_lsb = 8;
  localparam int pos_run = 0;
  localparam int sys_keep_w = 10;
  // synchroniser lanes
  localparam int ln_sclk = 0;
  localparam int ln_csn = 1;
  localparam int ln_mosi = 2;
  localparam int ln_kilo = 3;
  localparam int ln_fast = 4;
  localparam int ln_gpio = 5;
  localparam logic [8:0] sync_rst = 9'h002;
  typedef enum logic [1:0]
  {
    src_internal = 2'b00,
    src_ext_low = 2'b01,
    src_ext_high = 2'b10,
    src_ext_high_div = 2'b11
  } stcc_src_t;
  typedef enum logic [1:0]
  {
    st_idle = 2'b00,
    st_cmd = 2'b01,
    st_data = 2'b10,
    st_done = 2'b11
  } stcc_state_t;
endpackage

//--- stcc_top_properties.sv
// port-level properties of the slot timing and clock block
`timescale 1ns/1ps
`default_nettype none
module stcc_top_properties #(
  parameter int hf_div = 32
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic miso_oe,
  input wire logic kilo_osc_on,
  input wire logic [1:0] clock_source_select,
  input wire logic [1:0] clock_pin_select,
  input wire logic hf_ext_sel,
  input wire logic [3:0] clock_pin_route,
  input wire logic run_state,
  input wire logic [3:0] slot_count_select,
  input wire logic [11:0] slot_enable,
  input wire logic period_tick,
  input wire logic afe_reset
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // registers back at defaults, outputs follow a cycle later
  sequence s_defaults;
    !run_state && slot_count_select == 4'h0 ##1
      !kilo_osc_on && clock_source_select == 2'h0 && !afe_reset;
  endsequence
  AST_SOFT_RESET:
    assert property (afe_reset |-> s_defaults)
    else $error("registers not at defaults after soft reset");
  AST_TICK_PULSE:
    assert property (period_tick |=> !period_tick)
    else $error("period tick longer than one cycle");
  AST_STANDBY_TICK:
    assert property (!run_state && !$past(run_state) &&
      !$past(run_state, 2) |-> !period_tick)
    else $error("period tick in standby");
  AST_SLOT_A:
    assert property (run_state && slot_count_select == 4'h0 |=>
      slot_enable == 12'h001)
    else $error("code zero does not run slot A alone");
  AST_SLOT_OFF:
    assert property (!run_state |=> slot_enable == 12'h000)
    else $error("slots enabled in standby");
  AST_HF_EXT:
    assert property (hf_ext_sel == clock_source_select[1])
    else $error("external high clock flag wrong");
  AST_PIN_ROUTE:
    assert property (clock_pin_route == ((clock_source_select == 2'h0) ?
      4'h0 : 4'h1 << clock_pin_select))
    else $error("clock pin route wrong");
  AST_FRAME_END:
    assert property (cs_n [*8] |-> !miso_oe)
    else $error("serial output driven outside a frame");
endmodule
bind stcc_top stcc_top_properties #(.hf_div(hf_div)) i_props (.clk, .arst_n,
  .cs_n, .miso_oe, .kilo_osc_on, .clock_source_select, .clock_pin_select,
  .hf_ext_sel, .clock_pin_route, .run_state, .slot_count_select,
  .slot_enable, .period_tick, .afe_reset);
`default_nettype wire

//--- stcc_top_tb_top.sv
// self-checking bench for the slot timing and clock block
`timescale 1ns/1ps
`default_nettype none
module stcc_top_tb_top;
  localparam logic [14:0] a_low = stcc_pkg::addr_period_low;
  localparam logic [14:0] a_high = stcc_pkg::addr_period_high;
  localparam logic [14:0] a_sys = stcc_pkg::addr_system_control;
  localparam logic [14:0] a_op = stcc_pkg::addr_operating_mode;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic sclk = 1'b0;
  logic cs_n = 1'b1;
  logic mosi = 1'b0;
  logic osc_kilo_clk = 1'b0;
  logic osc_fast_clk = 1'b0;
  logic [3:0] gpio_in = 4'h0;
  logic miso, miso_oe, kilo_osc_on, fast_slow_osc_on, slow_osc_choice;
  logic hf_ext_sel, run_state, period_tick, afe_reset;
  logic [1:0] clock_source_select, clock_pin_select, p;
  logic [3:0] clock_pin_route, slot_count_select;
  logic [11:0] slot_enable;
  logic [15:0] rd;
  logic [15:0] sv [4] = '{16'h0001, 16'h0006, 16'h0140, 16'h0340};
  logic [15:0] gv [4] = '{16'h03e8, 16'h0258, 16'h02bc, 16'h0578};
  int n_fail = 0;
  int cmp_count = 0;
  realtime t0;
  always #2.5 clk = ~clk;
  always #100 osc_kilo_clk = ~osc_kilo_clk;
  always #60 osc_fast_clk = ~osc_fast_clk;
  always #70 gpio_in = ~gpio_in;
  stcc_top #(.hf_div(2)) i_stcc_top (.clk, .arst_n, .sclk, .cs_n, .mosi,
    .osc_kilo_clk, .osc_fast_clk, .gpio_in, .miso, .miso_oe, .kilo_osc_on,
    .fast_slow_osc_on, .slow_osc_choice, .clock_source_select,
    .clock_pin_select, .hf_ext_sel, .clock_pin_route, .run_state,
    .slot_count_select, .slot_enable, .period_tick, .afe_reset);
  task automatic clks(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one serial frame: address, write flag, data; read data lands in rd
  task automatic xfer(input logic wr, input logic [14:0] a,
    input logic [15:0] d);
    logic [31:0] f;
    f = {a, wr, d};
    rd = 16'h0000;
    clks(1);
    cs_n = 1'b0;
    clks(10);
    for (int i = 31; i >= 0; i--)
    begin
      mosi = f[i];
      clks(10);
      sclk = 1'b1;
      clks(10);
      if (i >= 1 && i <= 16)
        rd = {rd[14:0], miso};
      sclk = 1'b0;
    end
    clks(10);
    cs_n = 1'b1;
    clks(10);
  endtask
  task automatic tick;
    clks(1);
    for (int j = 0; j < 2000 && period_tick !== 1'b1; j++)
      clks(1);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #300us;
    n_fail++;
    close_out();
  end
  initial
  begin
    clks(2);
    arst_n = 1'b1;
    clks(4);
    // defaults, last address unmapped
    for (int k = 0; k < 5; k++)
    begin
      xfer(1'b0, a_low + 15'(k), 16'h0000);
      chk("reset read", (k == 0) ? 16'h2710 : 16'h0000, rd);
    end
    $display("test reset values done");
    xfer(1'b1, a_high, 16'hffff);
    xfer(1'b0, a_high, 16'h0000);
    chk("period high", 16'h007f, rd);
    xfer(1'b1, a_sys, 16'h7fff);
    xfer(1'b0, a_sys, 16'h0000);
    chk("system control", 16'h03ff, rd);
    xfer(1'b1, a_op, 16'hffff);
    xfer(1'b0, a_op, 16'h0000);
    chk("operating mode", 16'h0f01, rd);
    xfer(1'b1, a_high, 16'h0000);
    $display("test field widths done");
    for (int k = 0; k < 4; k++)
    begin
      p = 2'(k);
      xfer(1'b1, a_sys, {6'h00, p, p, 3'h0, p[0], p[1], ~p[0]});
      chk("clock outputs", {4'h0, p, p, p[1], p[0], p[1], ~p[0],
        (k == 0) ? 4'h0 : 4'h1 << p}, {4'h0, clock_source_select,
        clock_pin_select, hf_ext_sel, slow_osc_choice, fast_slow_osc_on,
        kilo_osc_on, clock_pin_route});
    end
    $display("test clock selects done");
    for (int k = 0; k < 16; k++)
    begin
      xfer(1'b1, a_op, {4'h0, 4'(k), 8'h01});
      chk("slot enable", (k > 10) ? 16'h0fff : 16'((1 << (k + 1)) - 1),
        {4'h0, slot_enable});
    end
    xfer(1'b1, a_op, 16'h0b00);
    chk("standby slots", 16'h0000, {4'h0, slot_enable});
    $display("test slot counts done");
    xfer(1'b1, a_low, 16'h0005);
    xfer(1'b1, a_op, 16'h0001);
    // gap between ticks on each low clock source
    for (int k = 0; k < 4; k++)
    begin
      xfer(1'b1, a_sys, sv[k]);
      tick();
      tick();
      t0 = $realtime;
      tick();
      chk("tick gap", gv[k], 16'(int'($realtime - t0)));
    end
    $display("test period ticks done");
    xfer(1'b1, a_high, 16'h0003);
    xfer(1'b1, a_sys, 16'h8001);
    xfer(1'b0, a_sys, 16'h0000);
    chk("soft reset bit", 16'h0000, rd);
    xfer(1'b0, a_low, 16'h0000);
    chk("period after soft reset", 16'h2710, rd);
    xfer(1'b0, a_high, 16'h0000);
    chk("high after soft reset", 16'h0000, rd);
    chk("run after soft reset", 16'h0000, {15'h0, run_state});
    $display("test soft reset done");
    close_out();
  end
endmodule
`default_nettype wire
